// ### shared/mrdp_pkg.sv
package mrdp_pkg;

    // clock rate
    localparam int CLK_HZ = 20_000_000;

    // overcurrent filter time in nanoseconds, nominal 7 us
    localparam int OVC_FILTER_NS      = 7000;
    // window limits in nanoseconds
    localparam int OVC_FILTER_MIN_NS  = 5250;
    localparam int OVC_FILTER_MAX_NS  = 8750;
    localparam int OVC_FILTER_CYC =
        (OVC_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int OVC_CNT_W = 8;

    // key deglitch time in nanoseconds
    localparam int KEY_FILTER_NS  = 10000;
    localparam int KEY_FILTER_CYC =
        (KEY_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int KEY_CNT_W = 8;

    localparam logic RELAY_OFF = 1'b0;

    typedef enum logic [2:0] {
        MRDP_IDLE,
        MRDP_ON,
        MRDP_THERMAL_OFF,
        MRDP_OVC_WAIT_KEY,
        MRDP_OVC_REACT,
        MRDP_RETRY_ON,
        MRDP_DIAG_OFF
    } mrdp_state_t;

    // sensed analog comparators, all asynchronous to clk
    typedef struct packed {
        logic key_on;
        logic battery_present;
        logic battery_above_uv;
        logic overcurrent;
        logic over_temp;
    } mrdp_sense_t;

    // controller requests
    typedef struct packed {
        logic power_latch_select;
        logic latch_hold;
        logic diag_off;
        logic relay_reactivate_cmd;
    } mrdp_ctrl_t;

endpackage

// ### logic/mrdp_main_relay.sv
`timescale 1ns/1ps

module mrdp_main_relay (
    input  wire logic               clk,                    // 20 MHz clock
    input  wire logic               rst_n,                  // async reset
    input  wire mrdp_pkg::mrdp_sense_t sense,               // async sense
    input  wire mrdp_pkg::mrdp_ctrl_t  ctrl,                // controller
    output logic                    main_relay_output,      // relay drive
    output logic                    relay_overcurrent_flag, // ovc status
    output logic                    regulators_keep_alive,  // regs enabled
    output logic                    key_filtered            // clean key
);

    mrdp_pkg::mrdp_sense_t sync1_reg, sync2_reg;

    logic [mrdp_pkg::KEY_CNT_W-1:0] key_cnt_reg, key_cnt_next;
    logic                           key_reg, key_next;
    logic                           key_fall;
    logic [mrdp_pkg::OVC_CNT_W-1:0] ovc_cnt_reg, ovc_cnt_next;
    logic                           ovc_trip;
    mrdp_pkg::mrdp_state_t          state_reg, state_next;
    logic                           relay_reg, relay_next;
    logic                           flag_reg, flag_next;
    logic                           keep_reg, keep_next;
    logic                           want_on;

    // thermal shutdown only counts while the battery supply is present
    function automatic logic thermal_trip(input mrdp_pkg::mrdp_sense_t s);
        return s.battery_present & s.over_temp;
    endfunction

    // two-stage synchroniser for all sensed inputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sense;
            sync2_reg <= sync1_reg;
        end
    end

    // key deglitch
    // counter clears whenever the synced level matches the filtered one
    always_comb begin
        key_cnt_next = '0;
        key_next     = key_reg;
        if (sync2_reg.key_on != key_reg) begin
            if (key_cnt_reg == mrdp_pkg::KEY_CNT_W'(
                    mrdp_pkg::KEY_FILTER_CYC - 1)) begin
                key_next = sync2_reg.key_on;
            end else begin
                key_cnt_next = key_cnt_reg + 1'b1;
            end
        end
    end

    assign key_fall = key_reg & ~key_next;

    // overcurrent filter, restart on drop
    // counts only while the relay drives, so a retry starts fresh
    always_comb begin
        ovc_cnt_next = '0;
        ovc_trip     = 1'b0;
        if (sync2_reg.overcurrent && relay_reg) begin
            if (ovc_cnt_reg == mrdp_pkg::OVC_CNT_W'(
                    mrdp_pkg::OVC_FILTER_CYC - 1)) begin
                ovc_trip = 1'b1;
            end else begin
                ovc_cnt_next = ovc_cnt_reg + 1'b1;
            end
        end
    end

    // on request from key or power latch hold
    assign want_on = key_reg |
        (ctrl.power_latch_select & ctrl.latch_hold);

    always_comb begin
        state_next = state_reg;
        relay_next = relay_reg;
        flag_next  = flag_reg;
        keep_next  = 1'b1;
        case (state_reg)
            mrdp_pkg::MRDP_IDLE: begin
                relay_next = mrdp_pkg::RELAY_OFF;
                // no switch-on into a pending thermal shutdown
                if (want_on && !ctrl.diag_off &&
                        !thermal_trip(sync2_reg)) begin
                    state_next = mrdp_pkg::MRDP_ON;
                    relay_next = 1'b1;
                end
            end
            mrdp_pkg::MRDP_ON: begin
                if (ovc_trip) begin
                    relay_next = mrdp_pkg::RELAY_OFF;
                    flag_next  = 1'b1;
                    // no battery: wait key edge, else react
                    state_next = sync2_reg.battery_present ?
                        mrdp_pkg::MRDP_OVC_REACT :
                        mrdp_pkg::MRDP_OVC_WAIT_KEY;
                end else if (thermal_trip(sync2_reg)) begin
                    relay_next = mrdp_pkg::RELAY_OFF;
                    state_next = mrdp_pkg::MRDP_THERMAL_OFF;
                end else if (ctrl.diag_off) begin
                    relay_next = mrdp_pkg::RELAY_OFF;
                    state_next = mrdp_pkg::MRDP_DIAG_OFF;
                end else if (!want_on) begin
                    relay_next = mrdp_pkg::RELAY_OFF;
                    state_next = mrdp_pkg::MRDP_IDLE;
                end
            end
            mrdp_pkg::MRDP_THERMAL_OFF: begin
                if (!sync2_reg.over_temp) begin
                    state_next = mrdp_pkg::MRDP_IDLE;
                end
            end
            mrdp_pkg::MRDP_OVC_WAIT_KEY: begin
                if (key_fall) begin
                    flag_next  = 1'b0;
                    state_next = mrdp_pkg::MRDP_IDLE;
                end
            end
            mrdp_pkg::MRDP_OVC_REACT: begin
                if (key_fall) begin
                    flag_next  = 1'b0;
                    state_next = mrdp_pkg::MRDP_IDLE;
                end else if (!sync2_reg.battery_above_uv) begin
                    flag_next  = 1'b0;
                    relay_next = 1'b1;
                    state_next = mrdp_pkg::MRDP_RETRY_ON;
                end else if (ctrl.relay_reactivate_cmd) begin
                    flag_next  = 1'b0;
                    relay_next = 1'b1;
                    state_next = mrdp_pkg::MRDP_ON;
                end
            end
            mrdp_pkg::MRDP_RETRY_ON: begin
                // second trip latches until key edge
                if (ovc_trip) begin
                    relay_next = mrdp_pkg::RELAY_OFF;
                    flag_next  = 1'b1;
                    state_next = mrdp_pkg::MRDP_OVC_WAIT_KEY;
                end else if (!want_on || ctrl.diag_off) begin
                    relay_next = mrdp_pkg::RELAY_OFF;
                    state_next = mrdp_pkg::MRDP_IDLE;
                end else if (thermal_trip(sync2_reg)) begin
                    relay_next = mrdp_pkg::RELAY_OFF;
                    state_next = mrdp_pkg::MRDP_THERMAL_OFF;
                end
            end
            mrdp_pkg::MRDP_DIAG_OFF: begin
                relay_next = mrdp_pkg::RELAY_OFF;
                if (!ctrl.diag_off) begin
                    state_next = mrdp_pkg::MRDP_IDLE;
                end
            end
            default: begin
                state_next = mrdp_pkg::MRDP_IDLE;
                relay_next = mrdp_pkg::RELAY_OFF;
                flag_next  = 1'b0;
            end
        endcase
    end

    // key filter state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key_cnt_reg <= '0;
            key_reg     <= 1'b0;
        end else begin
            key_cnt_reg <= key_cnt_next;
            key_reg     <= key_next;
        end
    end

    // overcurrent filter state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovc_cnt_reg <= '0;
        end else begin
            ovc_cnt_reg <= ovc_cnt_next;
        end
    end

    // relay control state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= mrdp_pkg::MRDP_IDLE;
            relay_reg   <= 1'b0;
            flag_reg    <= 1'b0;
            keep_reg    <= 1'b0;
        end else begin
            state_reg   <= state_next;
            relay_reg   <= relay_next;
            flag_reg    <= flag_next;
            keep_reg    <= keep_next;
        end
    end

    // flag follows latched overcurrent off state
    assign relay_overcurrent_flag = flag_reg;
    assign main_relay_output      = relay_reg;
    assign regulators_keep_alive  = keep_reg;
    assign key_filtered           = key_reg;

endmodule

// ### testbench/mrdp_monitor.sv
`timescale 1ns/1ps
module mrdp_monitor (
    input wire logic                  clk,                    // clock
    input wire logic                  rst_n,                  // reset
    input wire mrdp_pkg::mrdp_sense_t sense,                  // sensed
    input wire mrdp_pkg::mrdp_ctrl_t  ctrl,                   // requests
    input wire logic                  main_relay_output,      // relay
    input wire logic                  relay_overcurrent_flag, // ovc flag
    input wire logic                  regulators_keep_alive,  // regs on
    input wire logic                  key_filtered            // clean key
);
    // relay-on overcurrent limit: upper end of the filter window
    localparam int OVC_MAX_CYC = mrdp_pkg::OVC_FILTER_MAX_NS
        * (mrdp_pkg::CLK_HZ / 1_000_000) / 1000;
    logic [7:0] ovc_run_reg;
    logic [7:0] ovc_on_run_reg;
    logic [7:0] key_run_reg;
    logic       key_prev_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // run lengths of raw pins (overcurrent also counted only while the relay drives), saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovc_run_reg    <= 8'h00;
            ovc_on_run_reg <= 8'h00;
            key_run_reg    <= 8'h00;
            key_prev_reg   <= 1'b0;
        end else begin
            ovc_run_reg    <= !sense.overcurrent ? 8'h00 :
                ovc_run_reg + 8'(ovc_run_reg != 8'hff);
            ovc_on_run_reg <= !(sense.overcurrent && main_relay_output) ?
                8'h00 : ovc_on_run_reg + 8'(ovc_on_run_reg != 8'hff);
            key_run_reg    <= (sense.key_on != key_prev_reg) ? 8'h00 :
                key_run_reg + 8'(key_run_reg != 8'hff);
            key_prev_reg   <= sense.key_on;
        end
    end
    a_ovc_filter: assert property ($rose(relay_overcurrent_flag)
        |-> $past(ovc_run_reg, 3) >= 8'h87) else $error("early trip");
    a_ovc_deadline: assert property (
        ovc_on_run_reg <= 8'(OVC_MAX_CYC)) else $error("late trip");
    a_flag_off: assert property (relay_overcurrent_flag
        |-> !main_relay_output) else $error("flag with relay on");
    a_regs_alive: assert property ($past(rst_n)
        |-> regulators_keep_alive) else $error("regulators dropped");
    a_diag_off: assert property (ctrl.diag_off ##1 ctrl.diag_off
        |-> !main_relay_output) else $error("relay on in diag");
    a_key_glitch: assert property ($changed(key_filtered)
        |-> $past(key_run_reg, 3) >= 8'hbe) else $error("key glitch");
    a_thermal_off: assert property (
        (sense.over_temp && sense.battery_present) [*6]
        |-> !main_relay_output) else $error("hot relay on");
    a_flag_clear: assert property (
        $fell(relay_overcurrent_flag)
        |-> !key_filtered || $past(ctrl.relay_reactivate_cmd)
        || $past(ctrl.relay_reactivate_cmd, 2)
        || !$past(sense.battery_above_uv, 3)
        || !$past(sense.battery_above_uv, 4)) else $error("bad clear");
    a_relay_cause: assert property ($rose(main_relay_output)
        |-> $past(key_filtered) || $past(ctrl.power_latch_select)
        || $past(ctrl.relay_reactivate_cmd)
        || !$past(sense.battery_above_uv, 3)
        || !$past(sense.battery_above_uv, 4)) else $error("stray on");
    c_trip: cover property ($rose(relay_overcurrent_flag));
    c_clear: cover property ($fell(relay_overcurrent_flag));
    c_key: cover property ($fell(key_filtered));
    c_retry: cover property ($rose(main_relay_output)
        && !sense.battery_above_uv);
endmodule
bind mrdp_main_relay mrdp_monitor mon (.clk(clk), .rst_n(rst_n),
    .sense(sense), .ctrl(ctrl), .main_relay_output(main_relay_output),
    .relay_overcurrent_flag(relay_overcurrent_flag),
    .regulators_keep_alive(regulators_keep_alive),
    .key_filtered(key_filtered));

// ### testbench/mrdp_ctrl_model.sv
`timescale 1ns/1ps
module mrdp_ctrl_model (
    input  wire logic           clk,       // clock
    input  wire logic           latch_req, // hold power latch
    input  wire logic           diag_req,  // short-to-ground test
    input  wire logic           react_req, // restart request
    output mrdp_pkg::mrdp_ctrl_t ctrl      // controller outputs
);
    logic seen_reg = 1'b0;
    initial ctrl = '0;
    always @(posedge clk) begin
        ctrl.relay_reactivate_cmd <= react_req & ~seen_reg;
        seen_reg <= react_req;
        ctrl.diag_off <= diag_req;
        ctrl.power_latch_select <= latch_req;
        ctrl.latch_hold <= latch_req;
    end
endmodule

// ### testbench/mrdp_main_relay_bench.sv
`timescale 1ns/1ps
module mrdp_main_relay_bench;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  latch_req = 1'b0;
    logic                  diag_req = 1'b0;
    logic                  react_req = 1'b0;
    logic                  relay, flag, alive, keyf;
    mrdp_pkg::mrdp_sense_t sense = '0;
    mrdp_pkg::mrdp_ctrl_t  ctrl;
    int                    miscompares = 0;
    int                    comparisons = 0;
    int                    seed = 32'h6675_fbac;
    int                    len;
    mrdp_main_relay uut (.clk(clk), .rst_n(rst_n), .sense(sense),
        .ctrl(ctrl), .main_relay_output(relay),
        .relay_overcurrent_flag(flag), .regulators_keep_alive(alive),
        .key_filtered(keyf));
    mrdp_ctrl_model model (.clk(clk), .latch_req(latch_req),
        .diag_req(diag_req), .react_req(react_req), .ctrl(ctrl));
    function automatic logic [1:0] ovc_exp(input int n);
        return (n > mrdp_pkg::OVC_FILTER_CYC) ? 2'b01 : 2'b10;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pulse(input int n);
        sense.overcurrent = 1'b1;
        cyc(n);
        sense.overcurrent = 1'b0;
        cyc(1);
    endtask
    task automatic react();
        react_req = 1'b1;
        cyc(2);
        react_req = 1'b0;
        cyc(4);
    endtask
    task automatic key(input logic v);
        sense.key_on = v;
        cyc(210);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial forever #25 clk = ~clk;
    // watchdog
    initial begin
        #500_000;
        miscompares++;
        end_of_test();
    end
    initial begin
        cyc(4);
        rst_n = 1'b1;
        sense.battery_present = 1'b1;
        sense.battery_above_uv = 1'b1;
        sense.key_on = 1'b1;
        cyc(150);
        key(1'b0);
        chk({keyf, relay}, 2'b00);
        key(1'b1);
        chk({keyf, relay}, 2'b11);
        $display("key test done");
        for (int i = 0; i < 6; i++) begin
            len = 20 + (($random(seed) & 32'h0000_00ff) % 100);
            pulse(len);
        end
        cyc(4);
        chk({relay, flag}, 2'b10);
        for (len = 135; len <= 145; len += 10) begin
            pulse(len);
            cyc(4);
            chk({relay, flag}, ovc_exp(len));
        end
        react();
        chk({relay, flag}, 2'b10);
        sense.overcurrent = 1'b1;
        cyc(150);
        sense.battery_above_uv = 1'b0;
        cyc(6);
        chk({relay, flag}, 2'b10);
        cyc(150);
        react();
        chk({relay, flag}, 2'b01);
        $display("battery present trip test done");
        sense.battery_above_uv = 1'b1;
        sense.battery_present = 1'b0;
        key(1'b0);
        key(1'b1);
        cyc(150);
        react();
        chk({relay, flag}, 2'b01);
        sense.overcurrent = 1'b0;
        key(1'b0);
        chk({relay, flag}, 2'b00);
        key(1'b1);
        chk({relay, flag}, 2'b10);
        $display("no battery trip test done");
        sense.battery_present = 1'b1;
        sense.over_temp = 1'b1;
        cyc(6);
        chk({relay, flag}, 2'b00);
        sense.over_temp = 1'b0;
        cyc(6);
        chk({relay, flag}, 2'b10);
        diag_req = 1'b1;
        cyc(6);
        chk({relay, alive}, 2'b01);
        diag_req = 1'b0;
        latch_req = 1'b1;
        key(1'b0);
        chk({relay, keyf}, 2'b10);
        latch_req = 1'b0;
        cyc(6);
        chk({relay, alive}, 2'b01);
        $display("thermal diag latch test done");
        end_of_test();
    end
endmodule
